// ---- dtsc_defines.vh ----
// Constants for the dual temperature sensor conversion core
`ifndef DTSC_DEFINES_VH
`define DTSC_DEFINES_VH

`define DTSC_CLK_HZ 10000000
`define DTSC_MS_CYC (`DTSC_CLK_HZ / 1000)
`define DTSC_CONV_MS 12'd30
`define DTSC_RATE0_MS 12'd64
`define DTSC_RATE1_MS 12'd500
`define DTSC_RATE2_MS 12'd1000
`define DTSC_RATE3_MS 12'd2500

`define DTSC_REG_LOC_HI 8'h00
`define DTSC_REG_REMS_HI 8'h01
`define DTSC_REG_STATUS 8'h02
`define DTSC_REG_CFG1_RD 8'h03
`define DTSC_REG_RATE_RD 8'h04
`define DTSC_REG_REM_OS_LIM 8'h07
`define DTSC_REG_CFG1_WR 8'h09
`define DTSC_REG_RATE_WR 8'h0A
`define DTSC_REG_ONESHOT 8'h0F
`define DTSC_REG_REMS_LO 8'h10
`define DTSC_REG_OFS_HI 8'h11
`define DTSC_REG_OFS_LO 8'h12
`define DTSC_REG_REM_CRIT_LIM 8'h19
`define DTSC_REG_LOC_LIM 8'h20
`define DTSC_REG_LOC_LO 8'h30
`define DTSC_REG_REMU_HI 8'h31
`define DTSC_REG_REMU_LO 8'h32
`define DTSC_REG_CFG2 8'hBF

`define DTSC_PTR_RST 8'h00
`define DTSC_RATE_RST 8'h02
`define DTSC_CFG1_RST 8'h00
`define DTSC_CFG2_RST 8'h1F
`define DTSC_LIM_RST 8'h55
`define DTSC_CRIT_RST 8'h6E
`define DTSC_OFS_RST 8'h00

`define DTSC_STAT_BUSY 7
`define DTSC_CFG1_STOP 6
`define DTSC_CFG2_PIN_A0 0
`define DTSC_CFG2_FSEL_LO 1
`define DTSC_CFG2_FSEL_HI 2

`define DTSC_ADDR_LOW 7'h18
`define DTSC_ADDR_MID 7'h29
`define DTSC_ADDR_HIGH 7'h4C

`endif

// ---- dtsc_core.v ----
// Two-channel temperature conversion core with SMBus slave register access
// Summary of operation
// - Default rate: local, remote and register update done within one second.
// - Busy bit D7 of status 02h is high only during conversion.
// - Channels converted local then remote, fixed round robin.
// - Rate read at 04h, written 0Ah; slower rate adds idle, conversion under 72 ms.
// - Command pointer resets to 00h.
// - Conversion rate register resets to 02h, one cycle per second.
// - Local result reads zero until first local slot ends, remote until first cycle completes.
// - Remote and local over-temperature limits reset 55h, remote critical 6Eh.
// - Both remote offset bytes reset to 00h.
// - First configuration register resets to 00h: continuous, masks clear.
// - Second configuration register resets to 1Fh: filter on, pin is address.
// - Slave only: clock line is input, never driven or stretched.
// - Strap low gives 18h, mid 29h, high 4Ch.
// - Pin becomes alert output only when strapped high; address then 4Ch.
// - Strap level evaluated continuously while it is an address input.
// - Filter select bits D2,D1: 00 off, 11 on, others reserved.
// - Filter off: remote 11-bit signed and unsigned, 0.125 C, left-justified.
// - Filter on: remote 13-bit signed and unsigned, 0.03125 C, left-justified.
// - Local 11-bit signed, 0.125 C, saturates at +127.875 C.
// - Remote high byte read freezes low byte until low byte read.
// - One-shot write in standby runs one cycle; value dropped, reads zero.
// - Filter off: two lowest remote bits zero; signed and unsigned both held.
`timescale 1ns/1ps
`include "dtsc_defines.vh"

module dtsc_core #(
   parameter MS_DIV = `DTSC_MS_CYC
)(
   input wire clk,
   input wire rst_b,
   input wire smb_clk,
   input wire smb_dat_in,
   output reg smb_dat_out,
   output reg smb_dat_oe,
   input wire [1:0] addr_strap_pin,
   output reg shared_alert_strap_pin_out,
   output reg shared_alert_strap_pin_oe,
   input wire overtemp_flag,
   input wire signed [11:0] local_adc,
   input wire signed [13:0] remote_adc,
   output reg busy,
   output reg remote_active
);
   localparam C_IDLE = 4'b0001;
   localparam C_LOC = 4'b0010;
   localparam C_REM = 4'b0100;
   localparam C_WAIT = 4'b1000;
   localparam S_IDLE = 9'h001;
   localparam S_ADDR = 9'h002;
   localparam S_AACK = 9'h004;
   localparam S_CMD = 9'h008;
   localparam S_CACK = 9'h010;
   localparam S_WDAT = 9'h020;
   localparam S_WACK = 9'h040;
   localparam S_RDAT = 9'h080;
   localparam S_RACK = 9'h100;

   function [11:0] period_ms;
      input [7:0] code;
      begin
         case (code)
            8'h00: period_ms = `DTSC_RATE0_MS;
            8'h01: period_ms = `DTSC_RATE1_MS;
            8'h02: period_ms = `DTSC_RATE2_MS;
            default: period_ms = `DTSC_RATE3_MS;
         endcase
      end
   endfunction

   reg [7:0] rate_reg, cfg1_reg, cfg2_reg, ptr_reg;
   reg [7:0] rem_os_lim_reg, rem_crit_lim_reg, loc_lim_reg, ofs_hi_reg, ofs_lo_reg;
   reg [15:0] loc_word_reg, rems_word_reg, remu_word_reg;
   reg [7:0] frz_s_reg, frz_u_reg;
   reg frz_s_v_reg, frz_u_v_reg;
   reg signed [13:0] filt_reg;
   reg [3:0] cst_reg;
   reg [13:0] div_reg;
   reg ms_tick;
   reg [11:0] ms_reg;
   reg oneshot_reg;
   reg scl_m, scl_s, sda_m, sda_s, scl_q, sda_q;
   reg [1:0] strap_m, strap_s;
   reg [8:0] st_reg;
   reg [3:0] cnt_reg;
   reg [7:0] sr_reg, tx_reg;
   reg rw_reg;
   reg [6:0] my_addr;
   reg [7:0] rd_val;
   reg signed [13:0] filt_in, filt_next;
   reg [10:0] loc_sat;
   reg [12:0] rems_v, remu_v;
   reg filt_on;
   wire standby = cfg1_reg[`DTSC_CFG1_STOP];
   wire scl_rise = scl_s & ~scl_q;
   wire scl_fall = ~scl_s & scl_q;
   wire smb_start = scl_s & scl_q & sda_q & ~sda_s;
   wire smb_stop = scl_s & scl_q & ~sda_q & sda_s;
   wire wr_strobe = scl_fall & st_reg[2] == 1'b0 & (st_reg == S_WDAT) & (cnt_reg == 4'd8);
   wire rd_load = scl_fall & ((st_reg == S_AACK & rw_reg) | st_reg == S_RACK);

   // Strap and bus lines come from outside the clock domain
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_q <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_q <= 1'b1;
         strap_m <= 2'b00;
         strap_s <= 2'b00;
      end
      else
      begin
         scl_m <= smb_clk;
         scl_s <= scl_m;
         scl_q <= scl_s;
         sda_m <= smb_dat_in;
         sda_s <= sda_m;
         sda_q <= sda_s;
         strap_m <= addr_strap_pin;
         strap_s <= strap_m;
      end
   end

   always @*
   begin
      case (strap_s)
         2'b00: my_addr = `DTSC_ADDR_LOW;
         2'b01: my_addr = `DTSC_ADDR_MID;
         default: my_addr = `DTSC_ADDR_HIGH;
      endcase
      if (!cfg2_reg[`DTSC_CFG2_PIN_A0])
         my_addr = `DTSC_ADDR_HIGH;
      filt_on = cfg2_reg[`DTSC_CFG2_FSEL_HI] & cfg2_reg[`DTSC_CFG2_FSEL_LO];
      // Quarter-step smoothing; first samples settle from zero
      filt_next = filt_reg + ((remote_adc - filt_reg) >>> 2);
      // Report the sample just taken, not the previous state
      filt_in = filt_on ? filt_next : remote_adc;
      if (local_adc > 12'sd1023)
         loc_sat = 11'h3FF;
      else if (local_adc < -12'sd1024)
         loc_sat = 11'h400;
      else
         loc_sat = local_adc[10:0];
      if (filt_in > 14'sd4095)
         rems_v = 13'h0FFF;
      else if (filt_in < -14'sd4096)
         rems_v = 13'h1000;
      else
         rems_v = filt_in[12:0];
      if (filt_in < 14'sd0)
         remu_v = 13'h0000;
      else
         remu_v = filt_in[12:0];
      if (!filt_on)
      begin
         rems_v[1:0] = 2'b00;
         remu_v[1:0] = 2'b00;
      end
      case (ptr_reg)
         `DTSC_REG_LOC_HI: rd_val = loc_word_reg[15:8];
         `DTSC_REG_LOC_LO: rd_val = loc_word_reg[7:0];
         `DTSC_REG_REMS_HI: rd_val = rems_word_reg[15:8];
         `DTSC_REG_REMS_LO: rd_val = frz_s_v_reg ? frz_s_reg : rems_word_reg[7:0];
         `DTSC_REG_REMU_HI: rd_val = remu_word_reg[15:8];
         `DTSC_REG_REMU_LO: rd_val = frz_u_v_reg ? frz_u_reg : remu_word_reg[7:0];
         `DTSC_REG_STATUS: rd_val = {busy, 7'h00};
         `DTSC_REG_CFG1_RD: rd_val = cfg1_reg;
         `DTSC_REG_RATE_RD: rd_val = rate_reg;
         `DTSC_REG_CFG2: rd_val = cfg2_reg;
         `DTSC_REG_REM_OS_LIM: rd_val = rem_os_lim_reg;
         `DTSC_REG_REM_CRIT_LIM: rd_val = rem_crit_lim_reg;
         `DTSC_REG_LOC_LIM: rd_val = loc_lim_reg;
         `DTSC_REG_OFS_HI: rd_val = ofs_hi_reg;
         `DTSC_REG_OFS_LO: rd_val = ofs_lo_reg;
         default: rd_val = 8'h00;
      endcase
   end

   // SMBus slave; clock only sampled, data released as soon as possible
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_reg <= S_IDLE;
         cnt_reg <= 4'd0;
         sr_reg <= 8'h00;
         tx_reg <= 8'h00;
         rw_reg <= 1'b0;
         smb_dat_oe <= 1'b0;
         smb_dat_out <= 1'b0;
      end
      else if (smb_start)
      begin
         st_reg <= S_ADDR;
         cnt_reg <= 4'd0;
         smb_dat_oe <= 1'b0;
      end
      else if (smb_stop)
      begin
         st_reg <= S_IDLE;
         smb_dat_oe <= 1'b0;
      end
      else if (scl_rise)
      begin
         if (st_reg == S_ADDR || st_reg == S_CMD || st_reg == S_WDAT)
         begin
            sr_reg <= {sr_reg[6:0], sda_s};
            cnt_reg <= cnt_reg + 4'd1;
         end
         else if (st_reg == S_RDAT)
            cnt_reg <= cnt_reg + 4'd1;
         else if (st_reg == S_RACK && sda_s)
            st_reg <= S_IDLE;
      end
      else if (scl_fall)
      begin
         case (st_reg)
            S_ADDR:
               if (cnt_reg == 4'd8)
               begin
                  if (sr_reg[7:1] == my_addr)
                  begin
                     st_reg <= S_AACK;
                     rw_reg <= sr_reg[0];
                     smb_dat_oe <= 1'b1;
                  end
                  else
                     st_reg <= S_IDLE;
               end
            S_CMD:
               if (cnt_reg == 4'd8)
               begin
                  st_reg <= S_CACK;
                  smb_dat_oe <= 1'b1;
               end
            S_WDAT:
               if (cnt_reg == 4'd8)
               begin
                  st_reg <= S_WACK;
                  smb_dat_oe <= 1'b1;
               end
            S_AACK, S_RACK:
               if (rw_reg)
               begin
                  st_reg <= S_RDAT;
                  cnt_reg <= 4'd0;
                  tx_reg <= rd_val;
                  smb_dat_oe <= ~rd_val[7];
               end
               else
               begin
                  st_reg <= S_CMD;
                  cnt_reg <= 4'd0;
                  smb_dat_oe <= 1'b0;
               end
            S_CACK, S_WACK:
            begin
               st_reg <= S_WDAT;
               cnt_reg <= 4'd0;
               smb_dat_oe <= 1'b0;
            end
            S_RDAT:
               if (cnt_reg == 4'd8)
               begin
                  st_reg <= S_RACK;
                  smb_dat_oe <= 1'b0;
               end
               else
               begin
                  smb_dat_oe <= ~tx_reg[6];
                  tx_reg <= {tx_reg[6:0], 1'b0};
               end
            default: st_reg <= S_IDLE;
         endcase
      end
   end

   // Register file and pointer
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ptr_reg <= `DTSC_PTR_RST;
         rate_reg <= `DTSC_RATE_RST;
         cfg1_reg <= `DTSC_CFG1_RST;
         cfg2_reg <= `DTSC_CFG2_RST;
         rem_os_lim_reg <= `DTSC_LIM_RST;
         loc_lim_reg <= `DTSC_LIM_RST;
         rem_crit_lim_reg <= `DTSC_CRIT_RST;
         ofs_hi_reg <= `DTSC_OFS_RST;
         ofs_lo_reg <= `DTSC_OFS_RST;
         frz_s_reg <= 8'h00;
         frz_u_reg <= 8'h00;
         frz_s_v_reg <= 1'b0;
         frz_u_v_reg <= 1'b0;
         oneshot_reg <= 1'b0;
      end
      else
      begin
         if (scl_fall && st_reg == S_CMD && cnt_reg == 4'd8)
            ptr_reg <= sr_reg;
         // freeze and release of low bytes
         if (rd_load && ptr_reg == `DTSC_REG_REMS_HI)
         begin
            frz_s_reg <= rems_word_reg[7:0];
            frz_s_v_reg <= 1'b1;
         end
         if (rd_load && ptr_reg == `DTSC_REG_REMS_LO)
            frz_s_v_reg <= 1'b0;
         if (rd_load && ptr_reg == `DTSC_REG_REMU_HI)
         begin
            frz_u_reg <= remu_word_reg[7:0];
            frz_u_v_reg <= 1'b1;
         end
         if (rd_load && ptr_reg == `DTSC_REG_REMU_LO)
            frz_u_v_reg <= 1'b0;
         if (cst_reg == C_LOC)
            oneshot_reg <= 1'b0;
         // status, results and unknown offsets ignore writes
         if (wr_strobe)
         begin
            case (ptr_reg)
               `DTSC_REG_RATE_WR: rate_reg <= sr_reg;
               `DTSC_REG_CFG1_WR: cfg1_reg <= sr_reg;
               // alert function only when strapped high
               `DTSC_REG_CFG2: cfg2_reg <= {sr_reg[7:1], sr_reg[0] | ~strap_s[1]};
               `DTSC_REG_REM_OS_LIM: rem_os_lim_reg <= sr_reg;
               `DTSC_REG_REM_CRIT_LIM: rem_crit_lim_reg <= sr_reg;
               `DTSC_REG_LOC_LIM: loc_lim_reg <= sr_reg;
               `DTSC_REG_OFS_HI: ofs_hi_reg <= sr_reg;
               `DTSC_REG_OFS_LO: ofs_lo_reg <= sr_reg;
               `DTSC_REG_ONESHOT: oneshot_reg <= standby;
               default: oneshot_reg <= oneshot_reg;
            endcase
         end
      end
   end

   // Conversion sequencer on a millisecond enable
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         div_reg <= 14'd0;
         ms_tick <= 1'b0;
         ms_reg <= 12'd0;
         cst_reg <= C_IDLE;
         busy <= 1'b0;
         remote_active <= 1'b0;
         filt_reg <= 14'sd0;
         // local reads zero until first local slot ends, remote until first cycle
         loc_word_reg <= 16'h0000;
         rems_word_reg <= 16'h0000;
         remu_word_reg <= 16'h0000;
         shared_alert_strap_pin_out <= 1'b0;
         shared_alert_strap_pin_oe <= 1'b0;
      end
      else
      begin
         ms_tick <= (div_reg == MS_DIV - 1);
         div_reg <= (div_reg == MS_DIV - 1) ? 14'd0 : div_reg + 14'd1;
         if (ms_tick)
            ms_reg <= ms_reg + 12'd1;
         shared_alert_strap_pin_oe <= ~cfg2_reg[`DTSC_CFG2_PIN_A0] & overtemp_flag;
         case (cst_reg)
            C_IDLE:
               if (!standby || oneshot_reg)
               begin
                  cst_reg <= C_LOC;
                  ms_reg <= 12'd0;
                  busy <= 1'b1;
               end
            C_LOC:
               if (ms_tick && ms_reg == `DTSC_CONV_MS - 12'd1)
               begin
                  loc_word_reg <= {loc_sat, 5'h00};
                  cst_reg <= C_REM;
                  remote_active <= 1'b1;
               end
            // then remote; both within 72 ms
            C_REM:
               if (ms_tick && ms_reg == `DTSC_CONV_MS + `DTSC_CONV_MS - 12'd1)
               begin
                  filt_reg <= filt_next;
                  rems_word_reg <= {rems_v, 3'b000};
                  remu_word_reg <= {remu_v, 3'b000};
                  remote_active <= 1'b0;
                  // busy drops at end of conversions
                  busy <= 1'b0;
                  cst_reg <= standby ? C_IDLE : C_WAIT;
               end
            // idle fills out the rate period
            C_WAIT:
               if (standby)
                  cst_reg <= C_IDLE;
               else if (ms_tick && ms_reg >= period_ms(rate_reg) - 12'd1)
               begin
                  cst_reg <= C_LOC;
                  ms_reg <= 12'd0;
                  busy <= 1'b1;
               end
            default: cst_reg <= C_IDLE;
         endcase
      end
   end
endmodule

// ---- dtsc_assertions.sv ----
// Port-level checker for the conversion core, bound into every instance
`timescale 1ns/1ps
module dtsc_checker #(
   parameter MS_DIV = 10
)(
   input wire clk,
   input wire rst_b,
   input wire smb_clk,
   input wire smb_dat_out,
   input wire smb_dat_oe,
   input wire [1:0] addr_strap_pin,
   input wire shared_alert_strap_pin_out,
   input wire shared_alert_strap_pin_oe,
   input wire overtemp_flag,
   input wire busy,
   input wire remote_active
);
   localparam int BMAX = 72 * MS_DIV;
   localparam int LSLOT = 29 * MS_DIV;
   int bcnt;
   // Length of the running conversion, cleared in every gap
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
         bcnt <= 0;
      else
         bcnt <= busy ? bcnt + 1 : 0;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_busy_max;
      busy |-> bcnt < BMAX;
   endproperty
   a_busy_max: assert property (p_busy_max)
      else $error("busy held past conversion bound");
   property p_loc_first;
      $rose(busy) |-> !remote_active [*8];
   endproperty
   a_loc_first: assert property (p_loc_first)
      else $error("remote slot did not follow local slot");
   property p_rem_slot;
      $rose(remote_active) |-> busy && bcnt >= LSLOT;
   endproperty
   a_rem_slot: assert property (p_rem_slot)
      else $error("remote slot began early or outside busy");
   property p_od_dat;
      smb_dat_oe |-> !smb_dat_out;
   endproperty
   a_od_dat: assert property (p_od_dat)
      else $error("data line driven high");
   property p_dat_scl_low;
      $changed(smb_dat_oe) |-> !smb_clk;
   endproperty
   a_dat_scl_low: assert property (p_dat_scl_low)
      else $error("data changed while bus clock high");
   property p_alert_cause;
      shared_alert_strap_pin_oe |-> $past(overtemp_flag) && addr_strap_pin[1];
   endproperty
   a_alert_cause: assert property (p_alert_cause)
      else $error("alert pin driven without cause or strap high");
   property p_alert_od;
      shared_alert_strap_pin_oe |-> !shared_alert_strap_pin_out;
   endproperty
   a_alert_od: assert property (p_alert_od)
      else $error("alert pin driven high");
   property p_run;
      $rose(rst_b) |-> ##[0:2] busy;
   endproperty
   a_run: assert property (p_run)
      else $error("no conversion after reset");
endmodule
bind dtsc_core dtsc_checker #(.MS_DIV(MS_DIV)) u_chk (.clk(clk), .rst_b(rst_b),
   .smb_clk(smb_clk), .smb_dat_out(smb_dat_out), .smb_dat_oe(smb_dat_oe),
   .addr_strap_pin(addr_strap_pin), .overtemp_flag(overtemp_flag),
   .shared_alert_strap_pin_out(shared_alert_strap_pin_out),
   .shared_alert_strap_pin_oe(shared_alert_strap_pin_oe),
   .busy(busy), .remote_active(remote_active));

// ---- dtsc_host.sv ----
// Bus-master model: drives the bus clock and pulls the data line low
`timescale 1ns/1ps
module dtsc_host (
   output logic scl,
   output logic sda_oe,
   input wire logic sda
);
   initial
   begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   // Long low phase leaves room for the slave's synchroniser delay
   task automatic bitx(input logic b, output logic r);
      #300 sda_oe = ~b;
      #300 scl = 1'b1;
      #100 r = sda;
      #100 scl = 1'b0;
   endtask
   task automatic start;
      #300 sda_oe = 1'b0;
      #300 scl = 1'b1;
      #200 sda_oe = 1'b1;
      #200 scl = 1'b0;
   endtask
   task automatic stop;
      #300 sda_oe = 1'b1;
      #300 scl = 1'b1;
      #200 sda_oe = 1'b0;
      #400;
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(d[i], r);
      bitx(1'b1, r);
      ack = ~r;
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] c, d, output logic ok);
      logic k1, k2, k3;
      start;
      wbyte({a, 1'b0}, k1);
      wbyte(c, k2);
      wbyte(d, k3);
      stop;
      ok = k1 & k2 & k3;
   endtask
   // Single-byte read, closed by a NACK
   task automatic rd(input logic [6:0] a, input logic setp, input logic [7:0] c,
      output logic [7:0] d, output logic ok);
      logic k1, k2, k3, r;
      k1 = 1'b1;
      k2 = 1'b1;
      start;
      if (setp)
      begin
         wbyte({a, 1'b0}, k1);
         wbyte(c, k2);
         start;
      end
      wbyte({a, 1'b1}, k3);
      for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
      bitx(1'b1, r);
      stop;
      ok = k1 & k2 & k3;
   endtask
endmodule

// ---- dtsc_core_test.sv ----
// Self-checking bench for the conversion core
`timescale 1ns/1ps
module dtsc_core_test;
   localparam int MS = 10;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [1:0] strap = 2'h2;
   logic ovt = 1'b0;
   logic [11:0] ladc = 12'h0C9;
   logic [13:0] radc = 14'h0331;
   logic [6:0] adr = 7'h4C;
   wire scl, h_oe, sda, d_out, d_oe, a_out, a_oe, busy, ract;
   int n_errors = 0;
   int cmp_count = 0;
   always #50 clk = ~clk;
   assign sda = ~h_oe & ~(d_oe & ~d_out);
   dtsc_host host (.scl(scl), .sda_oe(h_oe), .sda(sda));
   dtsc_core #(.MS_DIV(MS)) uut (.clk(clk), .rst_b(rst_b), .smb_clk(scl),
      .smb_dat_in(sda), .smb_dat_out(d_out), .smb_dat_oe(d_oe),
      .addr_strap_pin(strap), .shared_alert_strap_pin_out(a_out),
      .shared_alert_strap_pin_oe(a_oe), .overtemp_flag(ovt), .local_adc(ladc),
      .remote_adc(radc), .busy(busy), .remote_active(ract));
   task automatic chk(input string nm, input logic [7:0] e, g);
      cmp_count++;
      if (g !== e)
      begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rr(input logic [7:0] c, e);
      logic [7:0] d;
      logic ok;
      // Host delays are whole clock periods; start off the sampling edge
      @(negedge clk);
      host.rd(adr, 1'b1, c, d, ok);
      chk($sformatf("ack %h", c), 8'h01, {7'h00, ok});
      chk($sformatf("reg %h", c), e, d);
   endtask
   task automatic ww(input logic [7:0] c, d);
      logic ok;
      @(negedge clk);
      host.wr(adr, c, d, ok);
      chk($sformatf("wack %h", c), 8'h01, {7'h00, ok});
   endtask
   // Bounded wait for a busy level, judged on the falling clock edge
   task automatic wb(input logic v);
      for (int i = 0; i < 40000 && busy !== v; i++) @(negedge clk);
      chk("busy", {7'h00, v}, {7'h00, busy});
   endtask
   task automatic conv(input logic [11:0] l, input logic [13:0] r);
      @(posedge clk);
      ladc <= l;
      radc <= r;
      wb(1'b0);
      wb(1'b1);
      wb(1'b0);
   endtask
   task automatic per(input int lo, hi);
      int n;
      n = 0;
      wb(1'b0);
      wb(1'b1);
      for (; n < 40000 && busy === 1'b1; n++) @(negedge clk);
      for (; n < 40000 && busy !== 1'b1; n++) @(negedge clk);
      chk("period", 8'h01, {7'h00, n >= lo && n <= hi});
   endtask
   task automatic t_reset;
      logic [7:0] d;
      logic ok;
      logic [15:0] tab [8] = '{16'h0402, 16'h0755, 16'h2055, 16'h196E,
         16'h1100, 16'h1200, 16'h0300, 16'hBF1F};
      @(negedge clk);
      host.rd(adr, 1'b0, 8'h00, d, ok);
      chk("first read", 8'h00, d);
      rr(8'h02, 8'h80);
      foreach (tab[i]) rr(tab[i][15:8], tab[i][7:0]);
      per(900 * MS, 1100 * MS);
   endtask
   task automatic t_format;
      ww(8'h0A, 8'h00);
      rr(8'h04, 8'h00);
      per(60 * MS, 130 * MS);
      ww(8'hBF, 8'h19);
      conv(12'h44C, 14'h0331);
      rr(8'h00, 8'h7F);
      rr(8'h30, 8'hE0);
      rr(8'h01, 8'h19);
      rr(8'h31, 8'h19);
      conv(12'h44C, 14'h033C);
      rr(8'h10, 8'h80);
      rr(8'h32, 8'h80);
      rr(8'h10, 8'hE0);
      conv(12'hFF8, 14'h3FE0);
      rr(8'h00, 8'hFF);
      rr(8'h30, 8'h00);
      rr(8'h01, 8'hFF);
      rr(8'h10, 8'h00);
      rr(8'h31, 8'h00);
      rr(8'h32, 8'h00);
   endtask
   task automatic t_shot;
      ww(8'h09, 8'h40);
      wb(1'b0);
      repeat (1500) @(negedge clk);
      chk("standby", 8'h00, {7'h00, busy});
      ww(8'h02, 8'hFF);
      rr(8'h02, 8'h00);
      ww(8'h0F, 8'hA5);
      wb(1'b1);
      wb(1'b0);
      repeat (1500) @(negedge clk);
      chk("standby again", 8'h00, {7'h00, busy});
      rr(8'h0F, 8'h00);
      ww(8'h09, 8'h00);
      wb(1'b1);
   endtask
   task automatic t_addr;
      logic [7:0] d;
      logic ok;
      logic [8:0] tab [3] = '{9'h018, 9'h0A9, 9'h14C};
      foreach (tab[i])
      begin
         @(posedge clk);
         strap <= tab[i][8:7];
         adr = tab[i][6:0];
         rr(8'h20, 8'h55);
      end
      @(negedge clk);
      host.rd(7'h18, 1'b1, 8'h20, d, ok);
      chk("foreign address", 8'h00, {7'h00, ok});
   endtask
   task automatic t_alert;
      @(posedge clk);
      strap <= 2'h0;
      ovt <= 1'b1;
      adr = 7'h18;
      ww(8'hBF, 8'h18);
      repeat (10) @(negedge clk);
      chk("alert strap low", 8'h00, {7'h00, a_oe});
      @(posedge clk);
      strap <= 2'h2;
      adr = 7'h4C;
      ww(8'hBF, 8'h18);
      repeat (10) @(negedge clk);
      chk("alert on", 8'h01, {7'h00, a_oe});
      @(posedge clk);
      ovt <= 1'b0;
      repeat (10) @(negedge clk);
      chk("alert off", 8'h00, {7'h00, a_oe});
   endtask
   task automatic finish_test;
      $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset;
      t_format;
      t_shot;
      t_addr;
      t_alert;
      finish_test;
   end
   initial
   begin
      #9000000;
      n_errors++;
      $display("ERROR watchdog expected done seen hang");
      finish_test;
   end
endmodule
